// File: hw/flp_lane_packer.v
// Purpose: frames code blocks on the wide input and output streams
// Assumes: one clock; block lengths arrive on the control stream
// Notes:   core side sees per-lane counts with every data beat
//
// How it works
// - encode input is hard bytes, byte i holds bits 8i+7..8i
// - input last marker checked against block end, not used for framing
// - single count mode: one count per block shared by all lanes
// - per-lane mode: 8-bit count per lane, 0 to 16
// - count means LLRs per lane for decode, hard bytes for encode
// - valid bytes sit in the low byte positions of each lane
// - lanes fill in order up to the bytes left in the block
// - last transfer shortened to the remaining block size
// - four 128-bit output lanes, width setting picks used lanes
// - decode output soft or hard by block select, encode always hard
// - no output transfer carries two blocks
// - soft output is 8-bit LLRs in triple order, passed unchanged
// - hard output packs bits in bytes, up to 64 per cycle
// - single output count mode: one count per block for all lanes
// - per-lane output mode: fresh 8-bit lane counts per transfer
// - output count last marker checked, not used for framing
// - hard output counts whole bytes, so lengths round to bytes
// - output counts trimmed so a constant count fits any block
// - control bit 14 selects hard output
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "flp_consts.vh"

module flp_lane_packer (
   input  wire                  mclk,
   input  wire                  sys_rst,
   input  wire [7:0]            regAddr,
   input  wire [31:0]           regWdata,
   input  wire                  regWr,
   input  wire                  regRd,
   output wire [31:0]           regRdata,
   input  wire                  ctrlValid,
   output wire                  ctrlReady,
   input  wire [31:0]           ctrlWord,
   input  wire [`FLP_LEN_W-1:0] ctrlInLen,
   input  wire [`FLP_LEN_W-1:0] ctrlOutLen,
   input  wire                  dinValid,
   output wire                  dinReady,
   input  wire [`FLP_DATA_W-1:0] dinData,
   input  wire                  dinLast,
   input  wire                  dinCntValid,
   output wire                  dinCntReady,
   input  wire [`FLP_CNT_W-1:0] dinCntData,
   input  wire                  dinCntLast,
   output wire                  coreInValid,
   input  wire                  coreInReady,
   output wire [`FLP_DATA_W-1:0] coreInData,
   output wire [`FLP_CNT_W-1:0] coreInLaneCnt,
   output wire                  coreInEnd,
   input  wire                  coreOutValid,
   output wire                  coreOutReady,
   input  wire [`FLP_DATA_W-1:0] coreOutData,
   output wire [`FLP_CNT_W-1:0] coreOutLaneCnt,
   input  wire                  doutCntValid,
   output wire                  doutCntReady,
   input  wire [`FLP_CNT_W-1:0] doutCntData,
   input  wire                  doutCntLast,
   output wire                  doutValid,
   input  wire                  doutReady,
   output wire [`FLP_DATA_W-1:0] doutData,
   output wire [`FLP_CNT_W-1:0] doutLaneCnt,
   output wire                  doutLast,
   output wire                  doutHard
);
   localparam S_IDLE = 3'b001;
   localparam S_CNT  = 3'b010;
   localparam S_RUN  = 3'b100;

   // software registers
   reg  [`FLP_CFG_W-1:0]   cfgFf;
   reg  [`FLP_ERR_W-1:0]   maskFf;
   reg  [31:0]             rdataFf;
   reg  [7:0]              inBlkFf;
   reg  [7:0]              outBlkFf;
   wire [`FLP_ERR_W-1:0]   errs;
   wire [`FLP_ERR_W-1:0]   errClr;
   reg  [31:0]             nxt_rdata;

   // input path state
   reg  [2:0]              inStFf;
   reg  [2:0]              nxt_inSt;
   reg  [`FLP_LEN_W-1:0]   inRemFf;
   reg  [`FLP_LEN_W-1:0]   nxt_inRem;
   reg  [`FLP_CNT_W-1:0]   inHoldFf;
   reg                     coreInVldFf;
   reg  [`FLP_DATA_W-1:0]  coreInDataFf;
   reg  [`FLP_CNT_W-1:0]   coreInCntFf;
   reg                     coreInEndFf;
   wire                    inModeLane;
   wire [`FLP_CNT_W-1:0]   inCntSel;
   wire [`FLP_CNT_W-1:0]   inLaneCnt;
   wire [`FLP_LEN_W-1:0]   inTotal;
   wire                    inFinal;
   wire                    inLoad;
   wire                    inCntOk;
   wire                    dinFire;
   wire                    dinCntFire;
   wire                    ctrlFire;

   // block descriptor handed from input to output side
   reg                     pendFf;
   reg  [`FLP_LEN_W-1:0]   pendLenFf;
   reg                     pendHardFf;
   wire                    pendTake;
   wire [16:0]             lenRnd;

   // output path state
   reg  [2:0]              outStFf;
   reg  [2:0]              nxt_outSt;
   reg  [`FLP_LEN_W-1:0]   outRemFf;
   reg  [`FLP_LEN_W-1:0]   nxt_outRem;
   reg  [`FLP_CNT_W-1:0]   outHoldFf;
   reg                     outHardFf;
   reg                     doutVldFf;
   reg  [`FLP_DATA_W-1:0]  doutDataFf;
   reg  [`FLP_CNT_W-1:0]   doutCntFf;
   reg                     doutLastFf;
   reg                     doutHardFf;
   wire                    outModeLane;
   wire [`FLP_CNT_W-1:0]   outCntSel;
   wire [`FLP_CNT_W-1:0]   outLaneCnt;
   wire [`FLP_LEN_W-1:0]   outTotal;
   wire                    outFinal;
   wire                    outLoad;
   wire                    outCntOk;
   wire                    coreOutFire;
   wire                    doutCntFire;

   // ---------------- input side ----------------
   assign inModeLane = cfgFf[`FLP_B_DINMODE];
   assign inCntSel   = inModeLane ? dinCntData : inHoldFf;

   flp_lane_trim u_in_trim (
      .cntWord (inCntSel),
      .perLane (inModeLane),
      .laneSel (cfgFf[`FLP_F_DINSEL]),
      .remain  (inRemFf),
      .laneCnt (inLaneCnt),
      .total   (inTotal),
      .isFinal (inFinal)
   );

   // one control word per block; held off while descriptor is pending
   assign ctrlReady = inStFf[0] & ~pendFf;
   assign ctrlFire  = ctrlValid & ctrlReady;

   assign inLoad  = ~coreInVldFf | coreInReady;
   assign inCntOk = ~inModeLane | dinCntValid;
   assign dinReady = inStFf[2] & inCntOk & inLoad;
   assign dinFire  = dinValid & dinReady;
   assign dinCntReady = inModeLane ? (inStFf[2] & dinValid & inLoad)
                                   : inStFf[1];
   assign dinCntFire  = dinCntValid & dinCntReady;

   always @* begin
      nxt_inSt  = inStFf;
      nxt_inRem = inRemFf;
      case (inStFf)
         S_IDLE: begin
            if (ctrlFire) begin
               nxt_inRem = ctrlInLen;
               nxt_inSt  = inModeLane ? S_RUN : S_CNT;
            end
         end
         S_CNT: begin
            if (dinCntFire) begin
               nxt_inSt = S_RUN;
            end
         end
         S_RUN: begin
            if (dinFire) begin
               nxt_inRem = inRemFf - inTotal;
               if (inFinal) begin
                  nxt_inSt = S_IDLE;
               end
            end
         end
         default: begin
            nxt_inSt = S_IDLE;
         end
      endcase
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         inStFf       <= S_IDLE;
         inRemFf      <= 16'h0000;
         inHoldFf     <= 32'h00000000;
         coreInVldFf  <= 1'b0;
         coreInDataFf <= {`FLP_DATA_W{1'b0}};
         coreInCntFf  <= 32'h00000000;
         coreInEndFf  <= 1'b0;
         inBlkFf      <= 8'h00;
      end else begin
         inStFf  <= nxt_inSt;
         inRemFf <= nxt_inRem;
         if (inStFf[1] && dinCntFire) begin
            inHoldFf <= dinCntData;
         end
         if (inLoad) begin
            coreInVldFf <= dinFire;
         end
         if (dinFire) begin
            // bytes pass in arrival order, low lane bytes first
            coreInDataFf <= dinData;
            coreInCntFf  <= inLaneCnt;
            coreInEndFf  <= inFinal;
         end
         if (dinFire && inFinal) begin
            inBlkFf <= inBlkFf + 8'h01;
         end
      end
   end

   assign coreInValid   = coreInVldFf;
   assign coreInData    = coreInDataFf;
   assign coreInLaneCnt = coreInCntFf;
   assign coreInEnd     = coreInEndFf;

   // last markers are checked only; framing comes from the lengths
   flp_tlast_check u_chk_din (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .fire    (dinFire),
      .lastIn  (dinLast),
      .lastExp (inFinal),
      .enable  (maskFf[`FLP_ERR_DIN]),
      .clear   (errClr[`FLP_ERR_DIN]),
      .err     (errs[`FLP_ERR_DIN])
   );

   flp_tlast_check u_chk_dincnt (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .fire    (dinCntFire),
      .lastIn  (dinCntLast),
      .lastExp (~inModeLane | inFinal),
      .enable  (maskFf[`FLP_ERR_DINCNT]),
      .clear   (errClr[`FLP_ERR_DINCNT]),
      .err     (errs[`FLP_ERR_DINCNT])
   );

   // ---------------- descriptor handoff ----------------
   assign pendTake = outStFf[0] & pendFf;
   // hard lengths are bits; whole bytes leave the core
   assign lenRnd = {1'b0, pendLenFf} + 17'h00007;

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pendFf     <= 1'b0;
         pendLenFf  <= 16'h0000;
         pendHardFf <= 1'b0;
      end else begin
         pendFf <= ctrlFire | (pendFf & ~pendTake);
         if (ctrlFire) begin
            pendLenFf  <= ctrlOutLen;
            // encode has no selection: always hard
            pendHardFf <= cfgFf[`FLP_B_ENC] | ctrlWord[`FLP_B_HARD];
         end
      end
   end

   // ---------------- output side ----------------
   assign outModeLane = cfgFf[`FLP_B_DOUTMODE];
   assign outCntSel   = outModeLane ? doutCntData : outHoldFf;

   flp_lane_trim u_out_trim (
      .cntWord (outCntSel),
      .perLane (outModeLane),
      .laneSel (cfgFf[`FLP_F_DOUTSEL]),
      .remain  (outRemFf),
      .laneCnt (outLaneCnt),
      .total   (outTotal),
      .isFinal (outFinal)
   );

   assign outLoad  = ~doutVldFf | doutReady;
   assign outCntOk = ~outModeLane | doutCntValid;
   assign coreOutReady = outStFf[2] & outCntOk & outLoad;
   assign coreOutFire  = coreOutValid & coreOutReady;
   assign doutCntReady = outModeLane ? (outStFf[2] & coreOutValid & outLoad)
                                     : outStFf[1];
   assign doutCntFire  = doutCntValid & doutCntReady;
   // the core is asked for exactly the trimmed byte counts
   assign coreOutLaneCnt = outLaneCnt;

   always @* begin
      nxt_outSt  = outStFf;
      nxt_outRem = outRemFf;
      case (outStFf)
         S_IDLE: begin
            if (pendFf) begin
               nxt_outRem = pendHardFf ? {2'h0, lenRnd[16:3]}
                                       : pendLenFf;
               nxt_outSt  = outModeLane ? S_RUN : S_CNT;
            end
         end
         S_CNT: begin
            if (doutCntFire) begin
               nxt_outSt = S_RUN;
            end
         end
         S_RUN: begin
            if (coreOutFire) begin
               nxt_outRem = outRemFf - outTotal;
               if (outFinal) begin
                  nxt_outSt = S_IDLE;
               end
            end
         end
         default: begin
            nxt_outSt = S_IDLE;
         end
      endcase
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         outStFf    <= S_IDLE;
         outRemFf   <= 16'h0000;
         outHoldFf  <= 32'h00000000;
         outHardFf  <= 1'b0;
         doutVldFf  <= 1'b0;
         doutDataFf <= {`FLP_DATA_W{1'b0}};
         doutCntFf  <= 32'h00000000;
         doutLastFf <= 1'b0;
         doutHardFf <= 1'b0;
         outBlkFf   <= 8'h00;
      end else begin
         outStFf  <= nxt_outSt;
         outRemFf <= nxt_outRem;
         if (pendTake) begin
            outHardFf <= pendHardFf;
         end
         if (outStFf[1] && doutCntFire) begin
            outHoldFf <= doutCntData;
         end
         if (outLoad) begin
            doutVldFf <= coreOutFire;
         end
         if (coreOutFire) begin
            // soft LLRs and hard bytes leave unchanged, low first
            doutDataFf <= coreOutData;
            doutCntFf  <= outLaneCnt;
            doutLastFf <= outFinal;
            doutHardFf <= outHardFf;
         end
         if (coreOutFire && outFinal) begin
            outBlkFf <= outBlkFf + 8'h01;
         end
      end
   end

   assign doutValid   = doutVldFf;
   assign doutData    = doutDataFf;
   assign doutLaneCnt = doutCntFf;
   assign doutLast    = doutLastFf;
   assign doutHard    = doutHardFf;

   // unused checks are switched off through interrupt_mask
   flp_tlast_check u_chk_doutcnt (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .fire    (doutCntFire),
      .lastIn  (doutCntLast),
      .lastExp (~outModeLane | outFinal),
      .enable  (maskFf[`FLP_ERR_DOUTCNT]),
      .clear   (errClr[`FLP_ERR_DOUTCNT]),
      .err     (errs[`FLP_ERR_DOUTCNT])
   );

   // ---------------- register port ----------------
   assign errClr = (regWr && regAddr == `FLP_OFS_STAT) ?
                   regWdata[`FLP_ERR_W-1:0] : 3'h0;

   always @* begin
      nxt_rdata = 32'h00000000;
      if (regRd) begin
         case (regAddr)
            `FLP_OFS_WIDTH: begin
               nxt_rdata = {25'h0000000, cfgFf};
            end
            `FLP_OFS_MASK: begin
               nxt_rdata = {29'h00000000, maskFf};
            end
            `FLP_OFS_STAT: begin
               nxt_rdata = {26'h0000000, ~outStFf[0], ~inStFf[0],
                            1'b0, errs};
            end
            `FLP_OFS_BLKCNT: begin
               nxt_rdata = {16'h0000, outBlkFf, inBlkFf};
            end
            default: begin
               nxt_rdata = 32'h00000000;
            end
         endcase
      end
   end

   // width settings should change only while both sides are idle
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cfgFf   <= `FLP_CFG_RST;
         maskFf  <= `FLP_MASK_RST;
         rdataFf <= 32'h00000000;
      end else begin
         rdataFf <= nxt_rdata;
         if (regWr && regAddr == `FLP_OFS_WIDTH) begin
            cfgFf <= regWdata[`FLP_CFG_W-1:0];
         end
         if (regWr && regAddr == `FLP_OFS_MASK) begin
            maskFf <= regWdata[`FLP_ERR_W-1:0];
         end
      end
   end

   assign regRdata = rdataFf;
endmodule

// File: shared/flp_consts.vh
// Purpose: shared constants of the stream lane packer
// Assumes: included by bare name from every design file
// Notes:   offsets are byte addresses on the plain register port
`ifndef FLP_CONSTS_VH
`define FLP_CONSTS_VH

// register offsets
`define FLP_OFS_WIDTH   8'h00
`define FLP_OFS_MASK    8'h04
`define FLP_OFS_STAT    8'h08
`define FLP_OFS_BLKCNT  8'h0c

// stream_width_config fields
`define FLP_F_DINSEL    1:0
`define FLP_F_DOUTSEL   3:2
`define FLP_B_DINMODE   4
`define FLP_B_DOUTMODE  5
`define FLP_B_ENC       6
`define FLP_CFG_W       7
`define FLP_CFG_RST     7'h0a

// interrupt_mask and status bits
`define FLP_ERR_DIN     0
`define FLP_ERR_DINCNT  1
`define FLP_ERR_DOUTCNT 2
`define FLP_ERR_W       3
`define FLP_MASK_RST    3'h7
`define FLP_B_INBUSY    4
`define FLP_B_OUTBUSY   5

// per-block control word
`define FLP_B_HARD      14

// lane geometry
`define FLP_LANE_MAX    8'h10
`define FLP_CNT_W       32
`define FLP_DATA_W      512
`define FLP_LEN_W       16

`endif

// File: hw/flp_lane_trim.v
// Purpose: per-lane byte counts trimmed to the bytes left in a block
// Assumes: four lanes, 8-bit count fields
// Notes:   purely combinational
`timescale 1ns/100ps
`include "flp_consts.vh"

module flp_lane_trim (
   input  wire [`FLP_CNT_W-1:0] cntWord,
   input  wire                  perLane,
   input  wire [1:0]            laneSel,
   input  wire [`FLP_LEN_W-1:0] remain,
   output wire [`FLP_CNT_W-1:0] laneCnt,
   output wire [`FLP_LEN_W-1:0] total,
   output wire                  isFinal
);
   wire [`FLP_LEN_W-1:0] left [0:4];

   assign left[0] = remain;

   genvar n;
   generate
      for (n = 0; n < 4; n = n + 1) begin : g_lane
         wire [7:0]            raw;
         wire                  act;
         wire [7:0]            req;
         wire [`FLP_LEN_W-1:0] take;
         // one shared value for every lane in single mode
         assign raw = perLane ? cntWord[8*n+7:8*n] : cntWord[7:0];
         assign act = (n == 0) || (laneSel == 2'h1 && n < 2) ||
                      (laneSel == 2'h2);
         // counts above sixteen would overrun a 128-bit lane
         assign req = act ? ((raw > `FLP_LANE_MAX) ? `FLP_LANE_MAX : raw)
                          : 8'h00;
         // lanes fill in order until the block runs out
         assign take = (left[n] < {8'h00, req}) ? left[n]
                                                : {8'h00, req};
         assign laneCnt[8*n+7:8*n] = take[7:0];
         assign left[n+1] = left[n] - take;
      end
   endgenerate

   assign total   = remain - left[4];
   assign isFinal = (left[4] == 16'h0000);
endmodule

// File: hw/flp_tlast_check.v
// Purpose: sticky flag for a last marker that disagrees with framing
// Assumes: fire marks an accepted transfer
// Notes:   a new mismatch wins over a clear in the same cycle
`timescale 1ns/100ps
`include "flp_consts.vh"

module flp_tlast_check (
   input  wire mclk,
   input  wire sys_rst,
   input  wire fire,
   input  wire lastIn,
   input  wire lastExp,
   input  wire enable,
   input  wire clear,
   output wire err
);
   reg  errFf;
   wire nxt_err;

   assign nxt_err = (fire & enable & (lastIn != lastExp)) |
                    (errFf & ~clear);

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         errFf <= 1'b0;
      end else begin
         errFf <= nxt_err;
      end
   end

   assign err = errFf;
endmodule

// File: tb/flp_lane_packer_props.sv
// Purpose: framing properties of the lane packer streams
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound to the top module by name
`timescale 1ns/100ps
module flp_lane_packer_props (
   input wire        mclk,
   input wire        sys_rst,
   input wire        ctrlValid,
   input wire        ctrlReady,
   input wire        dinValid,
   input wire        dinReady,
   input wire        coreInValid,
   input wire        coreInReady,
   input wire [31:0] coreInLaneCnt,
   input wire        coreInEnd,
   input wire        coreOutValid,
   input wire        coreOutReady,
   input wire        doutValid,
   input wire        doutReady,
   input wire [31:0] doutLaneCnt,
   input wire        doutLast
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   function automatic bit lanesOk(input [31:0] c);
      lanesOk = c[7:0] <= 8'h10 && c[15:8] <= 8'h10
         && c[23:16] <= 8'h10 && c[31:24] <= 8'h10;
   endfunction
   sequence s_inBeat; dinValid && dinReady; endsequence
   sequence s_outBeat; coreOutValid && coreOutReady; endsequence
   sequence s_inStall; coreInValid && !coreInReady; endsequence
   sequence s_outStall; doutValid && !doutReady; endsequence
   property p_ctrlOne; ctrlValid && ctrlReady |=> !ctrlReady; endproperty
   property p_inGo; s_inBeat |=> coreInValid; endproperty
   property p_inLane; coreInValid |-> lanesOk(coreInLaneCnt); endproperty
   property p_inHold;
      s_inStall |=> coreInValid && $stable(coreInLaneCnt)
         && $stable(coreInEnd);
   endproperty
   property p_inEnd;
      coreInValid && coreInEnd |-> coreInLaneCnt != 32'h0;
   endproperty
   property p_outGo; s_outBeat |=> doutValid; endproperty
   property p_outLane; doutValid |-> lanesOk(doutLaneCnt); endproperty
   property p_outHold;
      s_outStall |=> doutValid && $stable(doutLaneCnt) && $stable(doutLast);
   endproperty
   a_ctrlOne: assert property (p_ctrlOne)
      else $error("second block taken while busy");
   a_inGo: assert property (p_inGo)
      else $error("input beat not passed on");
   a_inLane: assert property (p_inLane)
      else $error("input lane count above sixteen");
   a_inHold: assert property (p_inHold)
      else $error("input beat changed while stalled");
   a_inEnd: assert property (p_inEnd)
      else $error("empty final input beat");
   a_outGo: assert property (p_outGo)
      else $error("output beat not presented");
   a_outLane: assert property (p_outLane)
      else $error("output lane count above sixteen");
   a_outHold: assert property (p_outHold)
      else $error("output beat changed while stalled");
endmodule

bind flp_lane_packer flp_lane_packer_props u_props (
   .mclk(mclk), .sys_rst(sys_rst), .ctrlValid(ctrlValid),
   .ctrlReady(ctrlReady), .dinValid(dinValid), .dinReady(dinReady),
   .coreInValid(coreInValid), .coreInReady(coreInReady),
   .coreInLaneCnt(coreInLaneCnt), .coreInEnd(coreInEnd),
   .coreOutValid(coreOutValid), .coreOutReady(coreOutReady),
   .doutValid(doutValid), .doutReady(doutReady),
   .doutLaneCnt(doutLaneCnt), .doutLast(doutLast)
);

// File: tb/flp_far_model.sv
// Purpose: downstream consumer with its output count stream
// Assumes: output counts in single-count mode
// Notes:   slow takes one result beat in four
`timescale 1ns/100ps
module flp_far_model (
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire        slow,
   input  wire [31:0] cntWord,
   input  wire        doutCntReady,
   input  wire        doutValid,
   output reg         doutCntValid,
   output reg  [31:0] doutCntData,
   output reg         doutCntLast,
   output reg         doutReady
);
   reg [1:0] tick_ff;
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_ff <= 2'h0;
         doutCntValid <= 1'b0;
         doutCntData <= 32'h0;
         doutCntLast <= 1'b0;
         doutReady <= 1'b0;
      end else begin
         tick_ff <= tick_ff + 2'h1;
         // one count per block, each marked last
         doutCntValid <= 1'b1;
         doutCntData <= cntWord;
         doutCntLast <= 1'b1;
         doutReady <= !slow || (tick_ff == 2'h3);
      end
   end
endmodule

// File: tb/flp_lane_packer_test.sv
// Purpose: directed checks of lane trimming and block framing
// Assumes: the bench stands in for core, upstream and software
// Notes:   core output side always offers data
`timescale 1ns/100ps
`include "flp_consts.vh"
module flp_lane_packer_test;
   reg                     mclk, sys_rst, regWr, regRd, slow;
   reg  [7:0]              regAddr;
   reg  [31:0]             regWdata, ctrlWord, dinCntData, farCnt, d;
   reg                     ctrlValid, dinValid, dinLast, dinCntValid;
   reg                     dinCntLast, coreInReady, coreOutValid;
   reg  [`FLP_LEN_W-1:0]   ctrlInLen, ctrlOutLen;
   reg  [`FLP_DATA_W-1:0]  dinData, coreOutData;
   wire [31:0]             regRdata, coreInLaneCnt, coreOutLaneCnt;
   wire [31:0]             doutLaneCnt, doutCntData;
   wire [`FLP_DATA_W-1:0]  coreInData, doutData;
   wire                    ctrlReady, dinReady, dinCntReady, coreInValid;
   wire                    coreInEnd, coreOutReady, doutCntValid, doutHard;
   wire                    doutCntReady, doutCntLast, doutValid;
   wire                    doutReady, doutLast;
   integer                 errors, samples_checked, k;
   reg  [32:0]             inQ[$];
   reg  [33:0]             outQ[$];

   // every bench signal carries the name of the port it drives
   flp_lane_packer DUT (.*);
   flp_far_model far (
      .mclk(mclk), .sys_rst(sys_rst), .slow(slow), .cntWord(farCnt),
      .doutCntReady(doutCntReady), .doutValid(doutValid),
      .doutCntValid(doutCntValid), .doutCntData(doutCntData),
      .doutCntLast(doutCntLast), .doutReady(doutReady)
   );

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (coreInValid === 1'b1 && coreInReady)
         inQ.push_back({coreInEnd, coreInLaneCnt});
      if (doutValid === 1'b1 && doutReady === 1'b1)
         outQ.push_back({doutHard, doutLast, doutLaneCnt});
   end

   task chk(input [33:0] got, input [33:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task reg_wr(input [7:0] a, input [31:0] v);
      begin
         regAddr <= a;
         regWdata <= v;
         regWr <= 1'b1;
         @(posedge mclk);
         regWr <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task reg_rd(input [7:0] a);
      begin
         regAddr <= a;
         regRd <= 1'b1;
         @(posedge mclk);
         regRd <= 1'b0;
         #1 d = regRdata;
         @(posedge mclk);
      end
   endtask
   // one block: descriptor, nb input beats, then wait for no results
   task run_blk(input [31:0] w, input [15:0] il, input [15:0] ol,
                input integer nb, input lastOk, input integer no);
      integer n, b;
      begin
         inQ.delete();
         outQ.delete();
         ctrlWord <= w;
         ctrlInLen <= il;
         ctrlOutLen <= ol;
         ctrlValid <= 1'b1;
         n = 0;
         b = 0;
         @(posedge mclk);
         while (ctrlReady !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n = n + 1;
         end
         ctrlValid <= 1'b0;
         dinValid <= 1'b1;
         while (b < nb && n < 300) begin
            dinLast <= (b == nb - 1) ? lastOk : 1'b0;
            @(posedge mclk);
            if (dinReady === 1'b1) b = b + 1;
            n = n + 1;
         end
         dinValid <= 1'b0;
         while (outQ.size() < no && n < 600) begin
            @(posedge mclk);
            n = n + 1;
         end
         if (n >= 600) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t block stalled", $time);
         end
      end
   endtask

   task t_regs;
      begin
         reg_rd(`FLP_OFS_WIDTH);
         chk(d, 34'h0a);
         reg_rd(`FLP_OFS_MASK);
         chk(d, 34'h7);
         reg_wr(8'h10, 32'hffff);
         reg_rd(8'h10);
         chk(d, 34'h0);
         $display("test regs done");
      end
   endtask
   task t_single;
      begin
         reg_wr(`FLP_OFS_WIDTH, 32'h0);
         dinCntData <= 32'h10;
         farCnt <= 32'h10;
         slow <= 1'b1;
         run_blk(32'h0, 16'd20, 16'd20, 2, 1'b1, 2);
         chk(inQ[0], {1'b0, 32'h10});
         chk(inQ[1], {1'b1, 32'h04});
         chk(outQ[0], {2'b00, 32'h10});
         chk(outQ[1], {2'b01, 32'h04});
         $display("test single count done");
      end
   endtask
   task t_lanes;
      begin
         reg_wr(`FLP_OFS_WIDTH, 32'h1a);
         dinCntData <= 32'h01020408;
         farCnt <= 32'h08;
         slow <= 1'b0;
         run_blk(32'h0, 16'd13, 16'd13, 1, 1'b1, 1);
         chk(inQ[0], {1'b1, 32'h00010408});
         chk(outQ[0], {2'b01, 32'h00000508});
         chk(coreInData[31:0], 34'h03020100);
         chk(doutData[31:0], 34'h0c0b0a09);
         $display("test lane fill done");
      end
   endtask
   // decode with hard select, then encode; input last left low on purpose
   task t_hard;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            reg_wr(`FLP_OFS_WIDTH, k ? 32'h4a : 32'h0a);
            dinCntData <= 32'h10;
            farCnt <= 32'h10;
            // encode carries information bytes only
            run_blk(k ? 32'h0 : 32'h4000, 16'd16, 16'd20, 1, 1'b0, 1);
            chk(inQ[0], {1'b1, 32'h10});
            chk(outQ[0], {2'b11, 32'h03});
            reg_rd(`FLP_OFS_STAT);
            chk(d[0], 34'h1);
            reg_wr(`FLP_OFS_STAT, 32'h7);
            reg_rd(`FLP_OFS_STAT);
            chk(d[2:0], 34'h0);
         end
         $display("test hard output done");
      end
   endtask

   task close_out;
      begin
         $display("checks %0d mismatches %0d", samples_checked, errors);
         if (errors == 0 && samples_checked > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   initial begin
      errors = 0;
      samples_checked = 0;
      sys_rst = 1'b1;
      {regWr, regRd, slow, ctrlValid, dinValid, dinLast} = 6'h0;
      {dinCntValid, dinCntLast, coreOutValid} = 3'h0;
      coreInReady = 1'b1;
      regAddr = 8'h0;
      {regWdata, ctrlWord, dinCntData, farCnt, d} = 160'h0;
      ctrlInLen = 16'h0;
      ctrlOutLen = 16'h0;
      // turbo triples packed low byte first
      dinData = {16{32'h03020100}};
      coreOutData = {16{32'h0c0b0a09}};
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      dinCntValid <= 1'b1;
      dinCntLast <= 1'b1;
      coreOutValid <= 1'b1;
      t_regs;
      t_single;
      t_lanes;
      t_hard;
      close_out;
   end
   initial begin
      #2000000;
      errors = errors + 1;
      close_out;
   end
endmodule
